// ==== rtl/srqu_top.v ====
/*
  Status bytes, service-request mask and request output, status readout
  as ASCII text and the framed state-string transfer in both directions.
  Assumes an outside parser that gives command pulses and mask values,
  a byte talker/listener with valid/ready, and a state memory port.
*/
`timescale 1ns/100ps
`include "srqu_map.vh"
module srqu_top
(
  input  wire        sys_clk_in,
  input  wire        rstn_in,
  input  wire        preset_in,
  input  wire        pwr_done_in,
  input  wire [2:0]  cmd_in,
  input  wire        cmd_valid_in,
  input  wire [7:0]  mask_pri_in,
  input  wire [7:0]  mask_ext_in,
  input  wire        busy_in,
  input  wire [7:0]  pri_event_in,
  input  wire        key_event_in,
  input  wire        service_done_in,
  input  wire        tx_ready_in,
  input  wire [7:0]  rx_data_in,
  input  wire        rx_valid_in,
  input  wire        rx_eoi_in,
  input  wire [7:0]  state_rd_data_in,
  output reg  [7:0]  tx_data_out,
  output reg         tx_valid_out,
  output reg         tx_eoi_out,
  output reg         rx_ready_out,
  output reg         srq_out,
  output reg  [7:0]  pri_status_out,
  output reg  [7:0]  ext_status_out,
  output reg  [7:0]  mask_pri_out,
  output reg  [7:0]  mask_ext_out,
  output reg  [12:0] state_addr_out,
  output reg  [7:0]  state_wr_data_out,
  output reg         state_wr_out,
  output reg         state_load_done_out,
  output reg         cmd_ready_out
);
  localparam S_IDLE  = 6'h01;
  localparam S_STAT  = 6'h02;
  localparam S_SOUT  = 6'h04;
  localparam S_SIN   = 6'h08;
  localparam S_WAIT  = 6'h10;
  localparam S_DRAIN = 6'h20;

  reg [5:0]  st_r;
  reg [2:0]  pend_cmd_r;
  reg [3:0]  idx_r;
  reg [12:0] cnt_r;
  reg [15:0] len_r;
  reg [7:0]  snap_pri_r;
  reg [7:0]  snap_ext_r;
  reg        fetch_r;

  wire [7:0] pri_nxt;
  wire [7:0] ext_nxt;
  wire       clr_read;
  wire       clr_cmd;
  wire       rise_hit;
  wire       tx_take;

  // ASCII digit of a byte: position 0 hundreds, 1 tens, 2 units.
  function [7:0] dec_digit;
    input [7:0] v;
    input [1:0] pos;
    reg   [7:0] q;
    begin
      q = 8'h00;
      case (pos)
        2'd0:    q = v / 8'd100;
        2'd1:    q = (v / 8'd10) % 8'd10;
        default: q = v % 8'd10;
      endcase
      dec_digit = `SRQU_ASCII_0 + q;
    end
  endfunction

  // Decimal digits of the payload count, position 0 thousands.
  function [7:0] len_digit;
    input [15:0] v;
    input [1:0]  pos;
    reg   [15:0] q;
    begin
      q = 16'h0000;
      case (pos)
        2'd0:    q = v / 16'd1000;
        2'd1:    q = (v / 16'd100) % 16'd10;
        2'd2:    q = (v / 16'd10) % 16'd10;
        default: q = v % 16'd10;
      endcase
      len_digit = `SRQU_ASCII_0 + q[7:0];
    end
  endfunction

  // Events set status bits; set wins over any clear in the same cycle.
  assign pri_nxt  = pri_event_in;
  assign ext_nxt  = {5'h00, pwr_done_in, key_event_in, 1'b0} & `SRQU_E_USED;
  assign clr_cmd  = cmd_valid_in && cmd_ready_out && cmd_in == `SRQU_CMD_CLEAR;
  assign tx_take  = tx_valid_out && tx_ready_in;
  assign clr_read = (st_r == S_STAT) && tx_take && tx_eoi_out;
  assign rise_hit = |((pri_nxt & ~pri_status_out & mask_pri_out) |
                      (ext_nxt & ~ext_status_out & mask_ext_out));

  always @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      pri_status_out <= 8'h00;
      ext_status_out <= 8'h00;
      mask_pri_out   <= 8'h00;
      mask_ext_out   <= 8'h00;
      srq_out        <= 1'b0;
    end
    else
    begin
      if (preset_in)
      begin
        mask_pri_out <= 8'h00;
        mask_ext_out <= 8'h00;
      end
      else if (cmd_valid_in && cmd_ready_out && cmd_in == `SRQU_CMD_MASK)
      begin
        mask_pri_out <= mask_pri_in;
        mask_ext_out <= mask_ext_in;
      end
      if (clr_read || clr_cmd || service_done_in)
      begin
        pri_status_out <= pri_nxt;
        ext_status_out <= ext_nxt;
      end
      else
      begin
        pri_status_out <= pri_status_out | pri_nxt;
        ext_status_out <= ext_status_out | ext_nxt;
      end
      if (rise_hit)
        srq_out <= 1'b1;
      else if (clr_read || clr_cmd || service_done_in)
        srq_out <= 1'b0;
    end
  end

  // Command sequencer and byte streams.
  always @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_r                <= S_IDLE;
      pend_cmd_r          <= `SRQU_CMD_NONE;
      idx_r               <= 4'h0;
      cnt_r               <= 13'h0000;
      len_r               <= 16'h0000;
      snap_pri_r          <= 8'h00;
      snap_ext_r          <= 8'h00;
      fetch_r             <= 1'b0;
      tx_data_out         <= 8'h00;
      tx_valid_out        <= 1'b0;
      tx_eoi_out          <= 1'b0;
      rx_ready_out        <= 1'b0;
      state_addr_out      <= 13'h0000;
      state_wr_data_out   <= 8'h00;
      state_wr_out        <= 1'b0;
      state_load_done_out <= 1'b0;
      cmd_ready_out       <= 1'b1;
    end
    else
    begin
      state_wr_out        <= 1'b0;
      state_load_done_out <= 1'b0;
      fetch_r             <= 1'b0;
      case (st_r)
        S_IDLE:
        begin
          idx_r <= 4'h0;
          cnt_r <= 13'h0000;
          if (cmd_valid_in && cmd_ready_out)
          begin
            if (cmd_in == `SRQU_CMD_STAT_OUT || cmd_in == `SRQU_CMD_STATE_OUT)
            begin
              pend_cmd_r    <= cmd_in;
              cmd_ready_out <= 1'b0;
              st_r          <= S_WAIT;
            end
            else if (cmd_in == `SRQU_CMD_STATE_IN)
            begin
              cmd_ready_out <= 1'b0;
              rx_ready_out  <= 1'b1;
              len_r         <= 16'h0000;
              st_r          <= S_SIN;
            end
          end
        end
        S_WAIT:
        begin
          if (!busy_in)
          begin
            snap_pri_r <= pri_status_out;
            snap_ext_r <= ext_status_out;
            st_r <= (pend_cmd_r == `SRQU_CMD_STAT_OUT) ? S_STAT : S_SOUT;
          end
        end
        S_STAT:
        begin
          // Text "ppp,eee": each byte as three digits, comma between.
          if (!tx_valid_out || tx_take)
          begin
            if (tx_take && tx_eoi_out)
            begin
              tx_valid_out  <= 1'b0;
              tx_eoi_out    <= 1'b0;
              cmd_ready_out <= 1'b1;
              st_r          <= S_IDLE;
            end
            else
            begin
              tx_valid_out <= 1'b1;
              idx_r        <= idx_r + 4'h1;
              if (idx_r < 4'h3)
                tx_data_out <= dec_digit(snap_pri_r, idx_r[1:0]);
              else if (idx_r == 4'h3)
                tx_data_out <= `SRQU_ASCII_COMMA;
              else
                tx_data_out <= dec_digit(snap_ext_r, idx_r[1:0]);
              tx_eoi_out <= (idx_r == 4'h6);
            end
          end
        end
        S_SOUT:
        begin
          // Preamble, four-digit count, then the state bytes.
          if (!tx_valid_out || tx_take)
          begin
            if (tx_take && tx_eoi_out)
            begin
              tx_valid_out  <= 1'b0;
              tx_eoi_out    <= 1'b0;
              cmd_ready_out <= 1'b1;
              st_r          <= S_IDLE;
            end
            else if (idx_r < 4'h6)
            begin
              tx_valid_out <= 1'b1;
              idx_r        <= idx_r + 4'h1;
              case (idx_r)
                4'h0:    tx_data_out <= `SRQU_PRE_0;
                4'h1:    tx_data_out <= `SRQU_PRE_1;
                default: tx_data_out <= len_digit(`SRQU_STATE_LEN, idx_r[1:0] - 2'd2);
              endcase
              state_addr_out <= 13'h0000;
              fetch_r        <= (idx_r == 4'h5);
            end
            else if (fetch_r)
              tx_valid_out <= 1'b0;
            else
            begin
              tx_valid_out   <= 1'b1;
              tx_data_out    <= state_rd_data_in;
              tx_eoi_out     <= ({3'h0, state_addr_out} == `SRQU_STATE_LEN - 16'h1);
              state_addr_out <= state_addr_out + 13'h1;
            end
          end
        end
        S_SIN:
        begin
          if (rx_valid_in)
          begin
            idx_r <= (idx_r == 4'hf) ? idx_r : idx_r + 4'h1;
            if (idx_r >= 4'h2 && idx_r < 4'h6)
              len_r <= len_r * 16'd10 + {8'h00, rx_data_in - `SRQU_ASCII_0};
            else if (idx_r >= 4'h6)
            begin
              if ({3'h0, cnt_r} < len_r)
              begin
                state_addr_out    <= cnt_r;
                state_wr_data_out <= rx_data_in;
                state_wr_out      <= 1'b1;
                cnt_r             <= cnt_r + 13'h1;
              end
            end
            if (rx_eoi_in)
            begin
              rx_ready_out        <= 1'b0;
              state_load_done_out <= 1'b1;
              cmd_ready_out       <= 1'b1;
              st_r                <= S_IDLE;
            end
          end
        end
        default:
        begin
          st_r          <= S_IDLE;
          cmd_ready_out <= 1'b1;
        end
      endcase
    end
  end
endmodule

// ==== inc/srqu_map.vh ====
/*
  Constants for the status and service-request unit: command codes,
  status bit positions, stream framing and sizes.
  Assumes a parser outside decodes host commands into one-cycle pulses.
*/
// Function
// - Status readout sends both bytes as ASCII decimal.
// - Completed readout clears both status bytes.
// - Clear command zeroes status, withdraws request.
// - Host mask bytes stored as primary, extended.
// - Power-on, test, preset zero mask; none requests.
// - Masked status bit rising raises service request.
// - Service cycle completion clears status, keeps mask.
// - Power-up done sets extended bit two.
// - Primary status bit meanings fixed as listed.
// - Extended bits two, one used; others zero.
// - Status bytes may be read separately; readout here always sends both.
// - State output command sends binary state string.
// - State input command loads controls from string.
// - Frame: preamble, byte count, then binary bytes.
// - End-or-identify goes with the final byte.
// - Payload 4390 bytes; receivers use sent count.
// - Value outputs wait for prior instructions done.
`ifndef SRQU_MAP_VH
`define SRQU_MAP_VH
`define SRQU_CMD_NONE      3'h0
`define SRQU_CMD_STAT_OUT  3'h1
`define SRQU_CMD_CLEAR     3'h2
`define SRQU_CMD_MASK      3'h3
`define SRQU_CMD_STATE_OUT 3'h4
`define SRQU_CMD_STATE_IN  3'h5
`define SRQU_P_EXT         7
`define SRQU_P_RQS         6
`define SRQU_P_SYNTAX      5
`define SRQU_P_SWEEP       4
`define SRQU_P_GET_REV     3
`define SRQU_P_GET         2
`define SRQU_P_ENTRY       1
`define SRQU_P_CAUTION     0
`define SRQU_E_PWR         2
`define SRQU_E_KEY         1
`define SRQU_E_USED        8'h06
`define SRQU_PRE_0         8'h23
`define SRQU_PRE_1         8'h41
`define SRQU_STATE_LEN     16'h1126
`define SRQU_ASCII_0       8'h30
`define SRQU_ASCII_COMMA   8'h2c
`endif

// ==== test/srqu_props.sv ====
/*
  Concurrent checks on the ports of the status and service-request unit.
  Assumes one clock domain and is bound onto every srqu_top instance.
*/
`timescale 1ns/100ps
`include "srqu_map.vh"
module srqu_props
(
  input wire       sys_clk_in,
  input wire       rstn_in,
  input wire       preset_in,
  input wire       pwr_done_in,
  input wire [2:0] cmd_in,
  input wire       cmd_valid_in,
  input wire [7:0] mask_pri_in,
  input wire [7:0] mask_ext_in,
  input wire       busy_in,
  input wire [7:0] pri_event_in,
  input wire       key_event_in,
  input wire       service_done_in,
  input wire       tx_ready_in,
  input wire [7:0] tx_data_out,
  input wire       tx_valid_out,
  input wire       tx_eoi_out,
  input wire       srq_out,
  input wire [7:0] pri_status_out,
  input wire [7:0] ext_status_out,
  input wire [7:0] mask_pri_out,
  input wire [7:0] mask_ext_out,
  input wire       cmd_ready_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  wire take  = cmd_valid_in && cmd_ready_out;
  wire clr   = take && cmd_in == `SRQU_CMD_CLEAR;
  wire quiet = pri_event_in == 8'h00 && !key_event_in && !pwr_done_in;
  hold_off_a: assert property (busy_in && !tx_valid_out |=> !tx_valid_out)
    else $error("talker started while busy");
  byte_stands_a: assert property (tx_valid_out && !tx_ready_in |=>
    tx_valid_out && $stable(tx_data_out) && $stable(tx_eoi_out)) else $error("byte dropped");
  mask_store_a: assert property (take && cmd_in == `SRQU_CMD_MASK && !preset_in |=>
    mask_pri_out == $past(mask_pri_in) && mask_ext_out == $past(mask_ext_in))
    else $error("mask not stored");
  preset_zero_a: assert property (preset_in && !take |=> {mask_pri_out, mask_ext_out} == 16'h0000)
    else $error("preset left mask");
  zero_mask_a: assert property ({mask_pri_out, mask_ext_out} == 16'h0000 && !srq_out |=> !srq_out)
    else $error("request with zero mask");
  srq_raise_a: assert property ((pri_event_in & mask_pri_out & ~pri_status_out) != 8'h00 |=> srq_out)
    else $error("masked rise without request");
  srq_keep_a: assert property (srq_out && !clr && !service_done_in &&
    !(tx_valid_out && tx_ready_in && tx_eoi_out) |=> srq_out) else $error("request dropped");
  clear_all_a: assert property (clr && quiet |=>
    pri_status_out == 8'h00 && ext_status_out == 8'h00 && !srq_out) else $error("clear failed");
  svc_clear_a: assert property (service_done_in && quiet && !take && !preset_in |=>
    {pri_status_out, ext_status_out} == 16'h0000 && $stable(mask_pri_out) && $stable(mask_ext_out))
    else $error("service completion wrong");
  ext_unused_a: assert property ((ext_status_out & ~`SRQU_E_USED) == 8'h00)
    else $error("unused extended bit set");
  pwr_flag_a: assert property (pwr_done_in |=> ext_status_out[`SRQU_E_PWR])
    else $error("power flag missing");
endmodule
bind srqu_top srqu_props chk (.*);

// ==== test/srqu_host.sv ====
/*
  Host controller model on the talker side: accepts bytes, records them.
  Assumes the talker holds each byte with valid until ready is sampled.
*/
`timescale 1ns/100ps
module srqu_host
(
  input  wire       clk_in,
  input  wire       slow_in,
  input  wire [7:0] tx_data_in,
  input  wire       tx_valid_in,
  input  wire       tx_eoi_in,
  output reg        tx_ready_out
);
  reg [7:0] got[$];
  integer   eoi_at;
  initial tx_ready_out = 1'b1;
  initial eoi_at = -1;
  always @(posedge clk_in)
  begin
    if (tx_valid_in && tx_ready_out)
    begin
      got.push_back(tx_data_in);
      if (tx_eoi_in)
        eoi_at = got.size() - 1;
    end
    tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
  end
endmodule

// ==== test/test_status_request_unit.sv ====
/*
  Self-checking bench for the status and service-request unit.
  Assumes the host model on the talker side and state memory returning its address XOR 8'h5a.
*/
`timescale 1ns/100ps
`include "srqu_map.vh"
module test_status_request_unit;
  reg         sys_clk_in, rstn_in, preset_in, pwr_done_in, cmd_valid_in, busy_in;
  reg         key_event_in, service_done_in, rx_valid_in, rx_eoi_in, slow;
  reg  [2:0]  cmd_in;
  reg  [7:0]  mask_pri_in, mask_ext_in, pri_event_in, rx_data_in;
  wire [7:0]  tx_data_out, pri_status_out, ext_status_out, mask_pri_out, mask_ext_out;
  wire [7:0]  state_wr_data_out;
  wire [12:0] state_addr_out;
  wire        tx_valid_out, tx_eoi_out, tx_ready_in, rx_ready_out, srq_out;
  wire        state_wr_out, state_load_done_out, cmd_ready_out;
  wire [7:0]  state_rd_data_in = state_addr_out[7:0] ^ 8'h5a;
  integer     n_fail, compares, cyc, i, bad, nwr, ndone;
  srqu_top dut (.*);
  srqu_host host (.clk_in(sys_clk_in), .slow_in(slow), .tx_data_in(tx_data_out),
    .tx_valid_in(tx_valid_out), .tx_eoi_in(tx_eoi_out), .tx_ready_out(tx_ready_in));
  task check(input [31:0] seen, input [31:0] exp);
  begin
    compares = compares + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task test_done;
  begin
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  task tick(input integer n);
  begin
    repeat (n) @(posedge sys_clk_in);
    #1;
  end
  endtask
  task idle;
    integer k;
  begin
    for (k = 0; k < 9000 && cmd_ready_out !== 1'b1; k = k + 1)
      tick(1);
  end
  endtask
  task cmd(input [2:0] c, input [7:0] a, input [7:0] b);
  begin
    idle;
    cmd_in = c;
    mask_pri_in = a;
    mask_ext_in = b;
    cmd_valid_in = 1'b1;
    tick(1);
    cmd_valid_in = 1'b0;
  end
  endtask
  task rx(input [7:0] d, input e);
    integer k;
  begin
    rx_data_in = d;
    rx_eoi_in = e;
    rx_valid_in = 1'b1;
    for (k = 0; k < 100 && rx_ready_out !== 1'b1; k = k + 1)
      tick(1);
    tick(1);
  end
  endtask
  initial
  begin
    sys_clk_in = 0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_fail = n_fail + 1;
      test_done;
    end
    if (state_wr_out === 1'b1)
    begin
      check(state_wr_data_out, 8'hc0 + nwr);
      nwr = nwr + 1;
    end
    if (state_load_done_out === 1'b1)
      ndone = ndone + 1;
  end
  initial
  begin
    {rstn_in, preset_in, pwr_done_in, cmd_valid_in, busy_in, key_event_in} = 6'h00;
    {service_done_in, rx_valid_in, rx_eoi_in, slow, cmd_in} = 7'h00;
    {mask_pri_in, mask_ext_in, pri_event_in, rx_data_in} = 32'h0;
    {n_fail, compares, cyc, nwr, ndone, bad} = 0;
    tick(4);
    rstn_in = 1'b1;
    check({pri_status_out, ext_status_out, mask_pri_out, mask_ext_out}, 32'h0);
    check({srq_out, cmd_ready_out}, 2'b01);
    pwr_done_in = 1'b1;
    tick(1);
    pwr_done_in = 1'b0;
    tick(1);
    check(ext_status_out, 8'h04);
    busy_in = 1'b1;
    slow = 1'b1;
    cmd(`SRQU_CMD_STAT_OUT, 8'h00, 8'h00);
    tick(20);
    check(host.got.size(), 0);
    busy_in = 1'b0;
    tick(1);
    idle;
    for (i = 0; i < 7; i = i + 1)
      check(host.got[i], ("000,004" >> (48 - 8 * i)) & 8'hff);
    check(host.eoi_at, 6);
    check({pri_status_out, ext_status_out}, 16'h0);
    slow = 1'b0;
    cmd(`SRQU_CMD_MASK, 8'h10, 8'h00);
    check({mask_pri_out, mask_ext_out}, 16'h1000);
    for (i = 0; i < 2; i = i + 1)
    begin
      pri_event_in = i ? 8'h10 : 8'h01;
      tick(1);
      pri_event_in = 8'h00;
      tick(12);
      check({srq_out, pri_status_out[4]}, i ? 2'b11 : 2'b00);
    end
    cmd(`SRQU_CMD_CLEAR, 8'h00, 8'h00);
    tick(1);
    check({srq_out, pri_status_out, ext_status_out}, 17'h0);
    cmd(`SRQU_CMD_MASK, 8'h00, 8'h02);
    key_event_in = 1'b1;
    tick(1);
    key_event_in = 1'b0;
    tick(2);
    check({srq_out, ext_status_out}, 9'h102);
    service_done_in = 1'b1;
    tick(1);
    service_done_in = 1'b0;
    tick(1);
    check({pri_status_out, ext_status_out, mask_pri_out, mask_ext_out}, 32'h2);
    check(srq_out, 1'b0);
    preset_in = 1'b1;
    tick(1);
    preset_in = 1'b0;
    key_event_in = 1'b1;
    tick(1);
    key_event_in = 1'b0;
    tick(3);
    check({srq_out, mask_pri_out, mask_ext_out}, 17'h0);
    host.got.delete();
    cmd(`SRQU_CMD_STATE_OUT, 8'h00, 8'h00);
    tick(1);
    idle;
    check(host.got.size(), 4396);
    for (i = 0; i < 6; i = i + 1)
      check(host.got[i], ("#A4390" >> (40 - 8 * i)) & 8'hff);
    check(host.eoi_at, 4395);
    for (i = 0; i < 4390; i = i + 1)
      if (host.got[6 + i] !== (i[7:0] ^ 8'h5a))
        bad = bad + 1;
    check(bad, 0);
    cmd(`SRQU_CMD_STATE_IN, 8'h00, 8'h00);
    for (i = 0; i < 10; i = i + 1)
      rx(i < 6 ? ("#A0003" >> (40 - 8 * i)) & 8'hff : 8'hba + i, i == 9);
    rx_valid_in = 1'b0;
    rx_eoi_in = 1'b0;
    tick(5);
    check({nwr[7:0], ndone[7:0]}, 16'h0301);
    test_done;
  end
endmodule
